// *** rtl/tmr16_pkg.sv ***
// tmr16_pkg: shared constants for the 16-bit timer with input capture
// assumes: an 8-bit register port, one system clock
package tmr16_pkg;
  // byte register indices on the 8-bit port
  localparam logic [3:0] A_CNT_LO  = 4'h0;
  localparam logic [3:0] A_CNT_HI  = 4'h1;
  localparam logic [3:0] A_CMPA_LO = 4'h2;
  localparam logic [3:0] A_CMPA_HI = 4'h3;
  localparam logic [3:0] A_CMPB_LO = 4'h4;
  localparam logic [3:0] A_CMPB_HI = 4'h5;
  localparam logic [3:0] A_CAP_LO  = 4'h6;
  localparam logic [3:0] A_CAP_HI  = 4'h7;
  localparam logic [3:0] A_CTRL_A  = 4'h8;
  localparam logic [3:0] A_CTRL_B  = 4'h9;
  localparam logic [3:0] A_FLAGS   = 4'hA;
  localparam logic [3:0] A_CMPCTL  = 4'hB;
  // timer_ctrl_b fields
  localparam int B_CS_LSB   = 0;
  localparam int B_WGM_HI   = 3;
  localparam int B_EDGE     = 6;
  localparam int B_FILT     = 7;
  // flags register fields
  localparam int F_OVF      = 0;
  localparam int F_CAP      = 1;
  localparam int F_CAPIE    = 2;
  // comparator_ctrl field
  localparam int C_SRC      = 0;
  // filter length in system clocks
  localparam int FILT_LEN   = 4;
  // wave modes taking top from the capture register
  localparam logic [3:0] WM_CTC_CAP  = 4'hC;
  localparam logic [3:0] WM_FPWM_CAP = 4'hE;
  localparam logic [3:0] WM_PC_CAP   = 4'hA;
  localparam logic [15:0] MAX_VAL    = 16'hFFFF;
  // AXI4-Lite word offsets of the controller
  localparam logic [3:0] X_CMD  = 4'h0;
  localparam logic [3:0] X_STAT = 4'h4;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// *** rtl/tmr16_if.sv ***
// tmr16_if: 8-bit register port between a bus master and the timer
// assumes: one access per cycle, read data combinational
`timescale 1ns/1ns
`default_nettype none
interface tmr16_if;
  logic [3:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq_ack;
  modport dev (input addr, wr, rd, wdata, irq_ack, output rdata);
  modport host (output addr, wr, rd, wdata, irq_ack, input rdata);
endinterface
`default_nettype wire

// *** rtl/tmr16_dev.sv ***
// tmr16_dev: 16-bit up/down timer with shared high-byte staging and capture
// assumes: timer_tick and capture inputs synchronous to CLK
`timescale 1ns/1ns
`default_nettype none
module tmr16_dev
  import tmr16_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic NRST,
  // register port
  tmr16_if.dev      BUS,
  // timing inputs
  input  wire logic TIMER_TICK,
  input  wire logic CAPTURE_PIN,
  input  wire logic COMPARATOR_OUT,
  // outputs
  output var  logic CAPTURE_IRQ,
  output var  logic OVERFLOW_IRQ,
  output var  logic [15:0] COUNT_VALUE
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  stage_q;
  logic [15:0] cnt_q, cmpa_q, cmpb_q, cap_q;
  logic [7:0]  ctla_q, ctlb_q, cmpctl_q;
  logic        ovf_q, capf_q, capie_q, down_q;
  logic [FILT_LEN-1:0] hist_q;
  logic        filt_q, lvl_q;

  wire logic [3:0] wmode = {ctlb_q[B_WGM_HI+1], ctlb_q[B_WGM_HI], ctla_q[1:0]};
  wire logic cap_top = (wmode == WM_CTC_CAP) || (wmode == WM_FPWM_CAP) ||
                       (wmode == WM_PC_CAP);
  wire logic running = (ctlb_q[B_CS_LSB+2:B_CS_LSB] != 3'h0);
  wire logic tick    = running && TIMER_TICK;
  wire logic wr_cnt  = BUS.wr && (BUS.addr == A_CNT_LO);
  wire logic wr_cap  = BUS.wr && (BUS.addr == A_CAP_LO) && cap_top;
  // top of count: capture or compare a in their modes, else fixed max
  wire logic [15:0] top = cap_top ? cap_q :
                          (wmode[3] || wmode == 4'h4) ? cmpa_q : MAX_VAL;
  wire logic pc_mode = (wmode == WM_PC_CAP) || (wmode[3:2] == 2'b10);
  wire logic ctc     = (wmode == 4'h4) || (wmode == WM_CTC_CAP);
  wire logic at_top  = (cnt_q == top);

  ////////////////////////////////////////////////////////////////////////
  // read mux; high bytes of counter and capture come from staging
  always_comb begin
    unique case (BUS.addr)
      A_CNT_LO:  BUS.rdata = cnt_q[7:0];
      A_CNT_HI:  BUS.rdata = stage_q;
      A_CMPA_LO: BUS.rdata = cmpa_q[7:0];
      A_CMPA_HI: BUS.rdata = cmpa_q[15:8];
      A_CMPB_LO: BUS.rdata = cmpb_q[7:0];
      A_CMPB_HI: BUS.rdata = cmpb_q[15:8];
      A_CAP_LO:  BUS.rdata = cap_q[7:0];
      A_CAP_HI:  BUS.rdata = stage_q;
      A_CTRL_A:  BUS.rdata = ctla_q;
      A_CTRL_B:  BUS.rdata = ctlb_q;
      A_FLAGS:   BUS.rdata = {5'h0, capie_q, capf_q, ovf_q};
      A_CMPCTL:  BUS.rdata = cmpctl_q;
      default:   BUS.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // staging register: written by any high write, loaded by counter and capture low reads
  always_ff @(posedge CLK) begin
    if (!NRST) stage_q <= 8'h00;
    else if (BUS.wr && BUS.addr[0] && BUS.addr < A_CTRL_A)
      stage_q <= BUS.wdata;
    else if (BUS.rd && BUS.addr == A_CNT_LO) stage_q <= cnt_q[15:8];
    else if (BUS.rd && BUS.addr == A_CAP_LO) stage_q <= cap_q[15:8];
  end

  // control and compare registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctla_q <= 8'h00; ctlb_q <= 8'h00; cmpctl_q <= 8'h00;
      cmpa_q <= 16'h0000; cmpb_q <= 16'h0000; capie_q <= 1'b0;
    end else if (BUS.wr) begin
      if (BUS.addr == A_CTRL_A) ctla_q <= BUS.wdata;
      if (BUS.addr == A_CTRL_B) ctlb_q <= BUS.wdata;
      if (BUS.addr == A_CMPCTL) cmpctl_q <= BUS.wdata;
      if (BUS.addr == A_FLAGS)  capie_q <= BUS.wdata[F_CAPIE];
      if (BUS.addr == A_CMPA_LO) cmpa_q <= {stage_q, BUS.wdata};
      if (BUS.addr == A_CMPB_LO) cmpb_q <= {stage_q, BUS.wdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter; the cpu write wins over any tick in the same cycle
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cnt_q <= 16'h0000; down_q <= 1'b0;
    end else if (wr_cnt) cnt_q <= {stage_q, BUS.wdata};
    else if (tick) begin
      if (pc_mode) begin
        if (!down_q && at_top) begin
          down_q <= 1'b1; cnt_q <= cnt_q - 16'h0001;
        end else if (down_q && cnt_q == 16'h0000) begin
          down_q <= 1'b0; cnt_q <= cnt_q + 16'h0001;
        end else if (down_q) cnt_q <= cnt_q - 16'h0001;
        else cnt_q <= cnt_q + 16'h0001;
      end else begin
        down_q <= 1'b0;
        cnt_q  <= at_top ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  // overflow: at max in normal/ctc, at top in pwm, at bottom in phase mode
  wire logic ovf_evt = tick && !wr_cnt && (pc_mode ?
                       (down_q && cnt_q == 16'h0001) :
                       (ctc ? (cnt_q == MAX_VAL) : at_top));
  wire logic ovf_clr = BUS.wr && BUS.addr == A_FLAGS && BUS.wdata[F_OVF];
  always_ff @(posedge CLK) begin
    if (!NRST) ovf_q <= 1'b0;
    else if (ovf_evt) ovf_q <= 1'b1;           // set beats clear
    else if (ovf_clr) ovf_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // capture source, filter and edge detector
  wire logic src = cmpctl_q[C_SRC] ? COMPARATOR_OUT : CAPTURE_PIN;
  wire logic all1 = &hist_q;
  wire logic all0 = ~|hist_q;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      hist_q <= '0; filt_q <= 1'b0; lvl_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[FILT_LEN-2:0], src};
      if (all1) filt_q <= 1'b1;
      else if (all0) filt_q <= 1'b0;
      lvl_q <= ctlb_q[B_FILT] ? filt_q : src;
    end
  end
  wire logic cur  = ctlb_q[B_FILT] ? filt_q : src;
  // capture is off while the capture register defines top
  wire logic cap_evt = !cap_top && (ctlb_q[B_EDGE] ? (cur && !lvl_q)
                                                   : (!cur && lvl_q));
  wire logic capf_clr = BUS.irq_ack ||
                        (BUS.wr && BUS.addr == A_FLAGS && BUS.wdata[F_CAP]);

  always_ff @(posedge CLK) begin
    if (!NRST) cap_q <= 16'h0000;
    else if (wr_cap) cap_q <= {stage_q, BUS.wdata};
    else if (cap_evt) cap_q <= cnt_q;
  end
  always_ff @(posedge CLK) begin
    if (!NRST) capf_q <= 1'b0;
    else if (cap_evt) capf_q <= 1'b1;
    else if (capf_clr) capf_q <= 1'b0;
  end

  assign CAPTURE_IRQ  = capf_q && capie_q;
  assign OVERFLOW_IRQ = ovf_q;
  assign COUNT_VALUE  = cnt_q;
endmodule
`default_nettype wire

// *** rtl/tmr16_host.sv ***
// tmr16_host: AXI4-Lite command slave driving the 8-bit timer port
// assumes: software follows the byte orders; one access per command
`timescale 1ns/1ns
`default_nettype none
module tmr16_host
  import tmr16_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic NRST,
  // axi4-lite write
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  output var  logic [1:0]  BRESP,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  // axi4-lite read
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  // timer port
  tmr16_if.host            BUS
);
  ////////////////////////////////////////////////////////////////////////
  // command word: [15:12] byte address, [9] capture irq acknowledge,
  // [8] read, [7:0] write data
  logic        aw_q, w_q, bv_q, rv_q, go_q, op_rd_q, ack_q;
  logic [3:0]  awa_q, opa_q, ws_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0]  br_q, rr_q;
  logic [7:0]  last_q;

  wire logic aw_hs = AWVALID && AWREADY;
  wire logic w_hs  = WVALID && WREADY;
  wire logic wr_go = aw_q && w_q && !bv_q;
  // a command is issued only when all four write strobes are set
  wire logic cmd_ok = (awa_q == X_CMD) && ws_q == 4'hF;
  wire logic [31:0] cmdw = wd_q;

  assign AWREADY = !aw_q && !bv_q;
  assign WREADY  = !w_q && !bv_q;
  assign ARREADY = !rv_q;
  assign BVALID  = bv_q;
  assign BRESP   = br_q;
  assign RVALID  = rv_q;
  assign RDATA   = rd_q;
  assign RRESP   = rr_q;
  // one port access per accepted command; byte order is software's job
  assign BUS.addr    = opa_q;
  assign BUS.wr      = go_q && !op_rd_q;
  assign BUS.rd      = go_q && op_rd_q;
  assign BUS.wdata   = last_q;
  assign BUS.irq_ack = go_q && ack_q;

  // write channel capture and response
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; awa_q <= 4'h0;
      wd_q <= 32'h0; br_q <= RESP_OK;
      ws_q <= 4'h0;
    end else begin
      if (aw_hs) begin aw_q <= 1'b1; awa_q <= AWADDR; end
      if (w_hs) begin
        w_q <= 1'b1;
        wd_q <= WDATA;
        ws_q <= WSTRB;
      end
      if (wr_go) begin
        aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b1;
        br_q <= (awa_q == X_CMD) ? RESP_OK : RESP_ERR;
      end else if (bv_q && BREADY) bv_q <= 1'b0;
    end
  end

  // issue one port cycle per command
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      go_q <= 1'b0; op_rd_q <= 1'b0; opa_q <= 4'h0; last_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      go_q <= wr_go && cmd_ok;
      if (wr_go) begin
        opa_q <= cmdw[15:12]; op_rd_q <= cmdw[8]; last_q <= cmdw[7:0];
        ack_q <= cmdw[9];
      end else if (go_q && op_rd_q) last_q <= BUS.rdata;
    end
  end

  // read channel: status holds last command byte (read byte after a read) and busy bit
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= RESP_OK;
    end else if (ARVALID && ARREADY) begin
      rv_q <= 1'b1;
      rd_q <= (ARADDR == X_STAT) ? {23'h0, go_q, last_q} : 32'h0;
      rr_q <= (ARADDR == X_STAT || ARADDR == X_CMD) ? RESP_OK : RESP_ERR;
    end else if (rv_q && RREADY) rv_q <= 1'b0;
  end
endmodule
`default_nettype wire

// *** sim/tmr16_properties.sv ***
// tmr16_properties: checks on the byte port and the timer pins
// assumes: placed beside the interface that joins host and device
`timescale 1ns/1ns
`default_nettype none
module tmr16_properties
  import tmr16_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // byte port
  input wire logic [3:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  // timer pins
  input wire logic        TIMER_TICK,
  input wire logic        CAPTURE_PIN,
  input wire logic        CAPTURE_IRQ,
  input wire logic        OVERFLOW_IRQ,
  input wire logic [15:0] COUNT_VALUE
);
  ////////////////////////////////////////////////////////////
  logic [7:0]  stg_q, cb_q;
  logic [15:0] cmp_q;
  logic [1:0]  ca_q;
  logic        ok_q, src_q, en_q;
  // decoded conditions
  wire logic       whi = wr && addr[0] && !addr[3];
  wire logic       wlo = wr && addr == A_CNT_LO;
  wire logic [3:0] wm  = {cb_q[4:3], ca_q};
  wire logic       run = cb_q[2:0] != 3'h0;
  wire logic       up  = run && wm == 4'h0 && TIMER_TICK && !wlo;
  wire logic       arm = cb_q[B_EDGE] && !src_q && en_q && !CAPTURE_IRQ;
  // shadow state; a capture low read hides the stage, so ok_q drops
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      {stg_q, ok_q, cmp_q, ca_q, cb_q, src_q, en_q} <= '0;
    end else begin
      if (whi) stg_q <= wdata;
      if (rd && addr == A_CNT_LO) stg_q <= COUNT_VALUE[15:8];
      if (whi || (rd && addr == A_CNT_LO)) ok_q <= 1'b1;
      if (rd && addr == A_CAP_LO) ok_q <= 1'b0;
      if (wr && addr == A_CMPA_LO) cmp_q <= {stg_q, wdata};
      if (wr && addr == A_CTRL_A) ca_q <= wdata[1:0];
      if (wr && addr == A_CTRL_B) cb_q <= wdata;
      if (wr && addr == A_CMPCTL) src_q <= wdata[C_SRC];
      if (wr && addr == A_FLAGS) en_q <= wdata[F_CAPIE];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking dclk @(posedge CLK); endclocking
  default disable iff (!NRST);
  // plain and filtered capture edges, then the flag response
  sequence s_raw;
    $rose(CAPTURE_PIN) && arm && wm == 4'h0 && !cb_q[B_FILT];
  endsequence
  sequence s_filt;
    $rose(CAPTURE_PIN) && arm && wm == 4'h0 && cb_q[B_FILT];
  endsequence
  sequence s_soon;
    ##[1:4] CAPTURE_IRQ;
  endsequence
  sequence s_late;
    !CAPTURE_IRQ [*4] ##[1:6] CAPTURE_IRQ;
  endsequence
  AST_CNT_WR:
    assert property (wlo |=> COUNT_VALUE == {$past(stg_q), $past(wdata)})
    else $error("counter low write lost a byte");
  AST_CNT_RD:
    assert property (rd && addr == A_CNT_LO |-> rdata == COUNT_VALUE[7:0])
    else $error("counter low read wrong");
  AST_STG_RD:
    assert property (rd && ok_q && (addr == A_CNT_HI || addr == A_CAP_HI)
      |-> rdata == stg_q) else $error("high read missed the stage");
  AST_CMP_HI:
    assert property (rd && addr == A_CMPA_HI |-> rdata == cmp_q[15:8])
    else $error("compare high read not direct");
  AST_STOP:
    assert property (!run && !wlo |=> $stable(COUNT_VALUE))
    else $error("stopped counter moved");
  AST_COUNT:
    assert property (up |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001)
    else $error("tick did not add one");
  AST_OVF:
    assert property (up && COUNT_VALUE == MAX_VAL |-> ##[1:2] OVERFLOW_IRQ)
    else $error("wrap did not raise overflow");
  AST_CAP:
    assert property (s_raw |-> s_soon) else $error("edge gave no capture");
  AST_FILT:
    assert property (s_filt |-> s_late) else $error("filter delay wrong");
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// testbench: host and device joined by the byte port, driven over axi
// assumes: design files compiled first; clock period 4 ns
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tmr16_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, tick = 1'b0, pin = 1'b0;
  logic        cmp = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, arready;
  logic        bvalid, rvalid, cirq, oirq;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdat = 32'h0, rdat;
  logic [1:0]  bresp, rresp;
  logic [15:0] cnt;
  int          errors = 0, check_count = 0, cyc = 0, stg = 0;
  int          mr[4], mb[16];
  tmr16_if tmr16_if_i ();
  tmr16_host tmr16_host_i (.CLK(clk), .NRST(nrst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdat), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdat), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .BUS(tmr16_if_i));
  tmr16_dev tmr16_dev_i (.CLK(clk), .NRST(nrst), .BUS(tmr16_if_i),
    .TIMER_TICK(tick), .CAPTURE_PIN(pin), .COMPARATOR_OUT(cmp),
    .CAPTURE_IRQ(cirq), .OVERFLOW_IRQ(oirq), .COUNT_VALUE(cnt));
  tmr16_properties tmr16_properties_i (.CLK(clk), .NRST(nrst),
    .addr(tmr16_if_i.addr), .wr(tmr16_if_i.wr), .rd(tmr16_if_i.rd),
    .wdata(tmr16_if_i.wdata), .rdata(tmr16_if_i.rdata),
    .TIMER_TICK(tick), .CAPTURE_PIN(pin), .CAPTURE_IRQ(cirq),
    .OVERFLOW_IRQ(oirq), .COUNT_VALUE(cnt));
  ////////////////////////////////////////////////////////////
  always #2 clk = ~clk;
  // random ticks only count while a clock source is selected
  always @(posedge clk) begin
    tick <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // readiness is looked at mid-cycle, so the edge decides alone
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdat <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdat;
    chk({14'h0000, rresp}, {14'h0000, RESP_OK});
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // one byte access: command, then poll status until not busy
  task automatic acc(input logic [3:0] l, input logic rdb,
                     input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0]  r;
    axw(X_CMD, {16'h0000, l, 3'h0, rdb, d}, r);
    chk({14'h0000, r}, {14'h0000, RESP_OK});
    repeat (2) @(posedge clk);
    s = 32'h0000_0100;
    while (s[8] !== 1'b0) axr(X_STAT, s);
    q = s[7:0];
  endtask
  ////////////////////////////////////////////////////////////
  function automatic bit captop();
    int m;
    m = ((mb[9] >> 1) & 12) | (mb[8] & 3);
    return m == 10 || m == 12 || m == 14;
  endfunction
  task automatic xb(input logic [3:0] l, input logic [7:0] d);
    logic [7:0] q;
    acc(l, 1'b0, d, q);
    if (l < 4'h8 && l[0]) stg = d;
    else if (l < 4'h8 && (l != A_CAP_LO || captop()))
      mr[l[2:1]] = stg * 256 + d;
    else if (l == A_FLAGS) mb[10] = (d & 4) | (mb[10] & 3 & ~d);
    else if (l > 4'h7) mb[l] = d;
  endtask
  task automatic cb(input logic [3:0] l);
    logic [7:0] q;
    int         e;
    acc(l, 1'b1, 8'h00, q);
    e = l > 4'h7 ? mb[l] : l[0] ? stg : mr[l[2:1]] & 255;
    if (l == A_CMPA_HI || l == A_CMPB_HI) e = mr[l[2:1]] >> 8;
    if (l == A_CNT_LO || l == A_CAP_LO) stg = mr[l[2:1]] >> 8;
    chk({8'h00, q}, 16'(e));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [7:0]  cfg [4];
    logic [1:0]  r;
    cfg = '{8'h40, 8'h00, 8'hC0, 8'h40};
    void'($urandom(32'h7D9040A5));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int l = 0; l < 12; l++) cb(4'(l));
    // store and fetch the counter, then share one high byte
    v = $urandom;
    xb(A_CNT_HI, v[15:8]);
    xb(A_CNT_LO, v[7:0]);
    cb(A_CNT_LO);
    cb(A_CNT_HI);
    xb(A_CMPA_HI, v[31:24]);
    xb(A_CMPA_LO, v[23:16]);
    xb(A_CMPB_LO, v[7:0]);
    xb(A_CNT_HI, 8'h5A);
    for (int l = 2; l < 6; l++) cb(4'(l));
    cb(A_CNT_HI);
    // capture value is refused outside capture-top modes
    for (int m = 0; m < 2; m++) begin
      xb(A_CTRL_B, m ? 8'h18 : 8'h00);
      xb(A_CAP_HI, v[15:8] ^ 8'(m));
      xb(A_CAP_LO, v[7:0]);
      cb(A_CAP_LO);
      cb(A_CAP_HI);
    end
    axw(4'h8, 32'h0000_0000, r);
    chk({14'h0000, r}, {14'h0000, RESP_ERR});
    // run across the wrap, then clear the overflow flag
    xb(A_CTRL_B, 8'h00);
    xb(A_CNT_HI, 8'hFF);
    xb(A_CNT_LO, 8'hF0);
    xb(A_CTRL_B, 8'h01);
    repeat (200) @(posedge clk);
    xb(A_CTRL_B, 8'h00);
    mb[10] = mb[10] | 1;
    cb(A_FLAGS);
    xb(A_FLAGS, 8'h01);
    cb(A_FLAGS);
    // rising, falling, filtered and comparator-sourced captures
    for (int k = 0; k < 4; k++) begin
      xb(A_CMPCTL, 8'(k == 3));
      xb(A_CTRL_B, cfg[k]);
      xb(A_FLAGS, 8'h06);
      v = $urandom;
      xb(A_CNT_HI, v[15:8]);
      xb(A_CNT_LO, v[7:0]);
      chk(cnt, 16'(mr[0]));
      @(posedge clk);
      if (k == 3) cmp <= ~cmp;
      else pin <= ~pin;
      repeat (12) @(posedge clk);
      mr[3] = mr[0];
      mb[10] = mb[10] | 2;
      chk({15'h0000, cirq}, 16'h0001);
      cb(A_CAP_LO);
      cb(A_CAP_HI);
      cb(A_FLAGS);
      // servicing the interrupt must drop the capture flag by itself
      if (k == 1) begin
        axw(X_CMD, {16'h0000, A_FLAGS, 4'h3, 8'h00}, r);
        chk({14'h0000, r}, {14'h0000, RESP_OK});
        mb[10] = mb[10] & 4;
        repeat (2) @(posedge clk);
        chk({15'h0000, cirq}, 16'h0000);
        cb(A_FLAGS);
      end
    end
    xb(A_FLAGS, 8'h02);
    chk({15'h0000, cirq}, 16'h0000);
    cb(A_FLAGS);
    wrap_up();
  end
endmodule
`default_nettype wire
